// File: core/uart_pkg.sv
// Constants and types shared by the serial port design
package uart_pkg;
  localparam logic [2:0]  ADDR_MODE   = 3'h0;
  localparam logic [2:0]  ADDR_STA    = 3'h1;
  localparam logic [2:0]  ADDR_TXREG  = 3'h2;
  localparam logic [2:0]  ADDR_RXREG  = 3'h3;
  localparam logic [2:0]  ADDR_BRG    = 3'h4;
  localparam logic [15:0] MODE_WMASK  = 16'hbbff;
  localparam logic [15:0] STA_WMASK   = 16'hfce0;
  localparam logic [15:0] RST_MODE    = 16'h0000;
  localparam logic [15:0] RST_STA     = 16'h0000;
  localparam logic [15:0] RST_DIV     = 16'h0000;
  // Mode register fields
  localparam int M_EN      = 15;
  localparam int M_RTSMD   = 11;
  localparam int M_PEN_HI  = 9;
  localparam int M_PEN_LO  = 8;
  localparam int M_LPBACK  = 6;
  localparam int M_ABAUD   = 5;
  localparam int M_RXINV   = 4;
  localparam int M_HISPD   = 3;
  localparam int M_PDS_HI  = 2;
  localparam int M_PDS_LO  = 1;
  localparam int M_STOP2   = 0;
  // Status and control register fields
  localparam int S_TXIM1   = 15;
  localparam int S_TXIM0   = 13;
  localparam int S_RXEN    = 12;
  localparam int S_BRK     = 11;
  localparam int S_TXEN    = 10;
  localparam int S_RXIM_HI = 7;
  localparam int S_RXIM_LO = 6;
  localparam int S_ADDEN   = 5;
  localparam int S_OVERRUN_FLAG    = 1;
  // Encodings
  localparam logic [1:0] PDS_8N  = 2'b00;
  localparam logic [1:0] PDS_8E  = 2'b01;
  localparam logic [1:0] PDS_8O  = 2'b10;
  localparam logic [1:0] PDS_9N  = 2'b11;
  localparam logic [1:0] PEN_RTS = 2'b01;
  localparam logic [1:0] PEN_FC  = 2'b10;
  localparam logic [1:0] PEN_CLK = 2'b11;
  localparam logic [1:0] TXIM_LOAD  = 2'b00;
  localparam logic [1:0] TXIM_DONE  = 2'b01;
  localparam logic [1:0] TXIM_EMPTY = 2'b10;
  localparam logic [3:0] OVS_STD = 4'hf;
  localparam logic [3:0] OVS_HI  = 4'h3;
  localparam logic [3:0] BRK_LAST = 4'hb;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [2:0] AB_EDGES = 3'h5;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b011,
    ST_PAR   = 3'b010,
    ST_STOP  = 3'b110
  } ser_state_t;
endpackage

// File: core/uart_port.sv
// Full-duplex serial port with baud generator, 4-deep queues and register port
// Operation
// - Free-running 16-bit baud timer; standard rate is clock over 16 times divisor+1.
// - High-speed select gives clock over 4 times divisor+1.
// - Writing the divisor clears the baud timer at once.
// - Setting transmit enable raises a transmit interrupt three cycles after the write.
// - In 8-bit mode a low-byte write enters the transmit queue.
// - Data loaded while disabled starts immediately once enabled; baud timer restarts cleared.
// - 9-bit mode accepts only full word writes to the transmit register.
// - Transmit interrupt follows the two-bit transmit interrupt mode.
// - Break request plus dummy character sends a break, the dummy value ignored.
// - After the break hardware clears break request, then sends queued sync.
// - Receive enable is bit 12 of status and control.
// - Receive interrupt follows the two-bit receive interrupt mode.
// - Overrun flag stays set until software clears it.
// - Reading receive data pops the queue; next entry brings own error flags.
// - Transmit and receive paths each hold four characters.
// - 8 or 9 data bits, even, odd or no parity, one or two stops.
// - 9-bit address detect keeps only characters whose ninth bit is 1.
// - Receiver flags parity, framing and overrun errors.
// - Baud clock output works only with high-speed select at 0.
// - Pin field 11 with port enabled drives 16x baud clock on request pin.
// - Pin field selects simplex or flow control use of request and clear pins.
// - Loopback, receive polarity and automatic baud detection are provided.
// - Transmit interrupt modes: load, all shifted out, queue emptied, reserved.
// - Break is start bit, twelve zeros, stop bit.
// - Parity field 00 8N, 01 8E, 10 8O, 11 9N; stop select one or two.
// - Pin field 00 data only, 01 request, 10 request and clear, 11 clock.
module uart_port
  import uart_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic [2:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [1:0]  i_wr_be,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_serial_in,
  output logic             o_serial_out,
  output logic             o_serial_out_oe,
  input  wire logic        i_clear_to_send_n,
  output logic             o_request_to_send_n,
  output logic             o_request_to_send_oe,
  output logic             o_tx_irq,
  output logic             o_rx_irq
);

  typedef struct packed {
    logic [15:0]      mode;
    logic [15:0]      sta_ctl;
    logic             overrun_flag;
    logic [15:0]      baud_divisor;
    logic [15:0]      brg_cnt;
    logic [3:0]       tx_sub;
    logic [3:0]       rx_sub;
    logic [3:0][8:0]  txf;
    logic [1:0]       txw;
    logic [1:0]       txr;
    logic [2:0]       txn;
    logic [3:0][10:0] rxf;
    logic [1:0]       rxw;
    logic [1:0]       rxr;
    logic [2:0]       rxn;
    ser_state_t       txs;
    logic [8:0]       tx_shift;
    logic             tx_par;
    logic [3:0]       tx_bit;
    logic             tx_brk;
    logic             tx_line;
    ser_state_t       rxs;
    logic [8:0]       rx_shift;
    logic [3:0]       rx_bit;
    logic             rx_parity_error_flag;
    logic             rx_prev;
    logic [2:0]       ab_edges;
    logic [22:0]      ab_cnt;
    logic [1:0]       irq_pipe;
    logic             tx_irq;
    logic             rx_irq;
    logic             rts_n;
    logic             bclk;
    logic [15:0]      rdata;
  } state_t;

  state_t q;
  state_t d;

  logic        en;
  logic        nine;
  logic        par_on;
  logic [3:0]  ovs_max;
  logic [3:0]  mid;
  logic        tick;
  logic        tx_end;
  logic        rx_smp;
  logic        rxline;
  logic        cts_ok;
  logic [15:0] bmask;
  logic [3:0]  last_bit;
  logic [10:0] rx_head;
  logic [8:0]  rx_word;
  logic        txen_old;

  assign en      = q.mode[M_EN];
  assign nine    = q.mode[M_PDS_HI:M_PDS_LO] == PDS_9N;
  assign par_on  = q.mode[M_PDS_HI:M_PDS_LO] == PDS_8E || q.mode[M_PDS_HI:M_PDS_LO] == PDS_8O;
  assign ovs_max = q.mode[M_HISPD] ? OVS_HI : OVS_STD;
  assign mid     = ovs_max >> 1;
  assign tick    = q.brg_cnt == q.baud_divisor;
  assign tx_end  = tick && q.tx_sub == ovs_max;
  assign rx_smp  = tick && q.rx_sub == mid;
  // Loopback feeds the transmitter straight back; no pin involved
  assign rxline  = q.mode[M_LPBACK] ? q.tx_line : (i_serial_in ^ q.mode[M_RXINV]);
  assign cts_ok  = q.mode[M_PEN_HI:M_PEN_LO] != PEN_FC || !i_clear_to_send_n;
  assign bmask   = {{8{i_wr_be[1]}}, {8{i_wr_be[0]}}};
  assign rx_head = q.rxf[q.rxr];
  assign rx_word = nine ? q.rx_shift : {1'b0, q.rx_shift[8:1]};
  assign txen_old = q.sta_ctl[S_TXEN];
  assign last_bit = q.tx_brk ? BRK_LAST : (nine ? 4'h8 : 4'h7);

  always_comb
  begin
    logic        push_ok;
    logic [8:0]  wchar;
    logic [1:0]  txim;
    logic [15:0] sta_rd;
    push_ok = 1'b0;
    wchar   = 9'h000;
    txim    = {q.sta_ctl[S_TXIM1], q.sta_ctl[S_TXIM0]};
    sta_rd  = 16'h0000;
    d = q;
    d.tx_irq   = 1'b0;
    d.rx_irq   = 1'b0;
    d.rdata    = 16'h0000;
    d.irq_pipe = {q.irq_pipe[0], 1'b0};

    // Baud timer
    if (tick)
    begin
      d.brg_cnt = 16'h0000;
      d.tx_sub = (q.tx_sub == ovs_max) ? 4'h0 : q.tx_sub + 4'h1;
      d.rx_sub = (q.rx_sub == ovs_max) ? 4'h0 : q.rx_sub + 4'h1;
    end
    else
    begin
      d.brg_cnt = q.brg_cnt + 16'h0001;
    end

    // Register writes
    if (i_wr)
    begin
      case (i_addr)
        ADDR_MODE:
        begin
          d.mode = ((q.mode & ~bmask) | (i_wdata & bmask)) & MODE_WMASK;
        end
        ADDR_STA:
        begin
          d.sta_ctl = ((q.sta_ctl & ~bmask) | (i_wdata & bmask)) & STA_WMASK;
          if (i_wr_be[0] && !i_wdata[S_OVERRUN_FLAG])
          begin
            d.overrun_flag = 1'b0;
          end
          if (!txen_old && d.sta_ctl[S_TXEN])
          begin
            // Restart from a cleared baud state so queued data leaves at once
            d.brg_cnt  = 16'h0000;
            d.tx_sub   = 4'h0;
            d.irq_pipe = {q.irq_pipe[0], 1'b1};
          end
          if (txen_old && !d.sta_ctl[S_TXEN])
          begin
            d.txn = 3'h0;
            d.txr = q.txw;
            d.txs = ST_IDLE;
          end
        end
        ADDR_BRG:
        begin
          d.baud_divisor = (q.baud_divisor & ~bmask) | (i_wdata & bmask);
          d.brg_cnt      = 16'h0000;
        end
        default:
        begin
          wchar = 9'h000;
        end
      endcase
    end

    // Transmitter
    case (q.txs)
      ST_IDLE:
      begin
        // A disable in this cycle has already flushed the queue; loading now would underflow it
        if (en && q.sta_ctl[S_TXEN] && d.sta_ctl[S_TXEN] && q.txn != 3'h0 && cts_ok)
        begin
          d.tx_shift = q.txf[q.txr];
          d.tx_par   = (^q.txf[q.txr][7:0]) ^ (q.mode[M_PDS_HI:M_PDS_LO] == PDS_8O);
          d.tx_brk   = q.sta_ctl[S_BRK];
          d.txr      = q.txr + 2'h1;
          d.txn      = d.txn - 3'h1;
          d.tx_sub   = 4'h0;
          d.tx_bit   = 4'h0;
          d.txs      = ST_START;
          if (txim == TXIM_LOAD || (txim == TXIM_EMPTY && q.txn == 3'h1))
          begin
            d.tx_irq = 1'b1;
          end
        end
      end
      ST_START:
      begin
        if (tx_end)
        begin
          d.txs = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (tx_end)
        begin
          d.tx_shift = {1'b0, q.tx_shift[8:1]};
          d.tx_bit   = q.tx_bit + 4'h1;
          if (q.tx_bit == last_bit)
          begin
            d.tx_bit = 4'h0;
            d.txs    = (q.tx_brk || !par_on) ? ST_STOP : ST_PAR;
          end
        end
      end
      ST_PAR:
      begin
        if (tx_end)
        begin
          d.txs = ST_STOP;
        end
      end
      ST_STOP:
      begin
        if (tx_end)
        begin
          if (q.mode[M_STOP2] && q.tx_bit == 4'h0 && !q.tx_brk)
          begin
            d.tx_bit = 4'h1;
          end
          else
          begin
            d.txs = ST_IDLE;
            if (q.tx_brk)
            begin
              d.sta_ctl[S_BRK] = 1'b0;
            end
            if (txim == TXIM_DONE && d.txn == 3'h0)
            begin
              d.tx_irq = 1'b1;
            end
          end
        end
      end
      default:
      begin
        d.txs = ST_IDLE;
      end
    endcase
    // Disable aborts a frame in flight; the state machine must not step on
    if (!d.sta_ctl[S_TXEN])
    begin
      d.txs = ST_IDLE;
    end
    if (q.irq_pipe[1])
    begin
      d.tx_irq = 1'b1;
    end

    // Transmit queue write; 9-bit mode needs both byte lanes
    if (i_wr && i_addr == ADDR_TXREG)
    begin
      push_ok = nine ? (i_wr_be == 2'b11) : i_wr_be[0];
      wchar   = nine ? i_wdata[8:0] : {1'b0, i_wdata[7:0]};
      if (push_ok && d.txn != FIFO_DEPTH)
      begin
        d.txf[q.txw] = wchar;
        d.txw = q.txw + 2'h1;
        d.txn = d.txn + 3'h1;
      end
    end

    // Line level follows the state just entered; idle is high
    case (d.txs)
      ST_START: d.tx_line = 1'b0;
      ST_DATA:  d.tx_line = d.tx_brk ? 1'b0 : d.tx_shift[0];
      ST_PAR:   d.tx_line = d.tx_par;
      default:  d.tx_line = 1'b1;
    endcase

    // Receiver
    d.rx_prev = rxline;
    if (!(en && q.sta_ctl[S_RXEN]))
    begin
      d.rxs = ST_IDLE;
    end
    else
    begin
      case (q.rxs)
        ST_IDLE:
        begin
          if (q.rx_prev && !rxline)
          begin
            d.rxs    = ST_START;
            d.rx_sub = 4'h0;
            d.rx_bit = 4'h0;
            d.rx_parity_error_flag = 1'b0;
          end
        end
        ST_START:
        begin
          if (rx_smp)
          begin
            // A glitch shorter than half a bit is dropped here
            d.rxs = rxline ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (rx_smp)
          begin
            d.rx_shift = {rxline, q.rx_shift[8:1]};
            d.rx_bit   = q.rx_bit + 4'h1;
            if (q.rx_bit == (nine ? 4'h8 : 4'h7))
            begin
              d.rxs = par_on ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR:
        begin
          if (rx_smp)
          begin
            d.rx_parity_error_flag = ((^q.rx_shift[8:1]) ^ (q.mode[M_PDS_HI:M_PDS_LO] == PDS_8O)) != rxline;
            d.rxs = ST_STOP;
          end
        end
        ST_STOP:
        begin
          if (rx_smp)
          begin
            d.rxs = ST_IDLE;
            if (!(nine && q.sta_ctl[S_ADDEN] && !rx_word[8]))
            begin
              if (q.rxn == FIFO_DEPTH)
              begin
                d.overrun_flag = 1'b1;
              end
              else
              begin
                d.rxf[q.rxw] = {q.rx_parity_error_flag, !rxline, rx_word};
                d.rxw = q.rxw + 2'h1;
                d.rxn = q.rxn + 3'h1;
                case (q.sta_ctl[S_RXIM_HI:S_RXIM_LO])
                  2'b10:   d.rx_irq = q.rxn == 3'h2;
                  2'b11:   d.rx_irq = q.rxn == 3'h3;
                  default: d.rx_irq = 1'b1;
                endcase
              end
            end
          end
        end
        default:
        begin
          d.rxs = ST_IDLE;
        end
      endcase
    end

    // Automatic baud: eight bit times between first and fifth falling edge of 55h
    if (q.mode[M_ABAUD])
    begin
      if (q.ab_edges != 3'h0)
      begin
        d.ab_cnt = q.ab_cnt + 23'h1;
      end
      if (q.rx_prev && !rxline)
      begin
        d.ab_edges = q.ab_edges + 3'h1;
        if (d.ab_edges == AB_EDGES)
        begin
          d.baud_divisor = (q.mode[M_HISPD] ? q.ab_cnt[20:5] : q.ab_cnt[22:7]) - 16'h0001;
          d.brg_cnt  = 16'h0000;
          d.mode[M_ABAUD] = 1'b0;
          d.ab_edges = 3'h0;
          d.ab_cnt   = 23'h0;
        end
      end
    end

    // Request pin: baud clock, simplex or flow control
    d.bclk = q.brg_cnt <= (q.baud_divisor >> 1);
    case (q.mode[M_PEN_HI:M_PEN_LO])
      PEN_CLK: d.rts_n = q.mode[M_HISPD] ? 1'b1 : q.bclk;
      PEN_RTS, PEN_FC:
      begin
        d.rts_n = q.mode[M_RTSMD] ? (q.txs == ST_IDLE) : (q.rxn == FIFO_DEPTH);
      end
      default: d.rts_n = 1'b1;
    endcase

    // Register reads; data appears in the following cycle
    sta_rd = q.sta_ctl;
    sta_rd[9] = q.txn == FIFO_DEPTH;
    sta_rd[8] = q.txn == 3'h0 && q.txs == ST_IDLE;
    sta_rd[4] = q.rxs == ST_IDLE;
    sta_rd[3] = q.rxn != 3'h0 && rx_head[10];
    sta_rd[2] = q.rxn != 3'h0 && rx_head[9];
    sta_rd[S_OVERRUN_FLAG] = q.overrun_flag;
    sta_rd[0] = q.rxn != 3'h0;
    if (i_rd)
    begin
      case (i_addr)
        ADDR_MODE: d.rdata = q.mode;
        ADDR_STA:  d.rdata = sta_rd;
        ADDR_BRG:  d.rdata = q.baud_divisor;
        ADDR_RXREG:
        begin
          d.rdata = {7'h00, rx_head[8:0]};
          if (q.rxn != 3'h0)
          begin
            d.rxr = q.rxr + 2'h1;
            d.rxn = d.rxn - 3'h1;
          end
        end
        default:   d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      q <= '0;
      q.mode <= RST_MODE;
      q.sta_ctl <= RST_STA;
      q.baud_divisor <= RST_DIV;
      q.tx_line <= 1'b1;
      q.rx_prev <= 1'b1;
      q.rts_n <= 1'b1;
      q.txs <= ST_IDLE;
      q.rxs <= ST_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_rdata              = q.rdata;
  assign o_serial_out         = q.tx_line;
  assign o_serial_out_oe      = en && q.sta_ctl[S_TXEN];
  assign o_request_to_send_n  = q.rts_n;
  assign o_request_to_send_oe = en && q.mode[M_PEN_HI:M_PEN_LO] != 2'b00;
  assign o_tx_irq             = q.tx_irq;
  assign o_rx_irq             = q.rx_irq;

endmodule

// File: dv/uart_port_properties.sv
// Concurrent checks on the serial port pins and register port
module uart_port_properties
  import uart_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_sys_rst,
  input wire logic [2:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [1:0]  i_wr_be,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        i_serial_in,
  input wire logic        o_serial_out,
  input wire logic        o_serial_out_oe,
  input wire logic        i_clear_to_send_n,
  input wire logic        o_request_to_send_n,
  input wire logic        o_request_to_send_oe,
  input wire logic        o_tx_irq,
  input wire logic        o_rx_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mode_q;
  logic [15:0] sta_q;
  logic [15:0] div_q;
  logic        bclk_on;

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] be);
    return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction

  // Software view only; hardware-cleared bits are not used below
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      mode_q <= RST_MODE;
      sta_q  <= RST_STA;
      div_q  <= RST_DIV;
    end
    else if (i_wr)
    begin
      if (i_addr == ADDR_MODE)
        mode_q <= merge(mode_q, i_wdata, i_wr_be) & MODE_WMASK;
      if (i_addr == ADDR_STA)
        sta_q <= merge(sta_q, i_wdata, i_wr_be);
      if (i_addr == ADDR_BRG)
        div_q <= merge(div_q, i_wdata, i_wr_be);
    end
  end

  assign bclk_on = mode_q[M_EN] && mode_q[M_PEN_HI:M_PEN_LO] == PEN_CLK && !mode_q[M_HISPD] && div_q == 16'h0003;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  rdata_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not cleared");
  rx_pulse_a: assert property (o_rx_irq |=> !o_rx_irq)
    else $error("receive interrupt longer than one cycle");
  idle_high_a: assert property (!o_serial_out_oe && $past(!o_serial_out_oe) |-> o_serial_out)
    else $error("transmit line not idle high");
  txen_irq_a: assert property (i_wr && i_addr == ADDR_STA && i_wr_be[1] && i_wdata[S_TXEN] && !sta_q[S_TXEN]
    && mode_q[M_EN] |-> ##3 o_tx_irq) else $error("no transmit interrupt after enable");
  rts_oe_a: assert property ($stable(mode_q) |->
    o_request_to_send_oe == (mode_q[M_EN] && mode_q[M_PEN_HI:M_PEN_LO] != 2'b00)) else $error("request pin enable wrong");
  tx_oe_a: assert property ($stable(mode_q) && $stable(sta_q) |->
    o_serial_out_oe == (mode_q[M_EN] && sta_q[S_TXEN])) else $error("transmit pin enable wrong");
  rx_off_a: assert property (!sta_q[S_RXEN] && !$past(sta_q[S_RXEN]) |-> !o_rx_irq)
    else $error("receive interrupt while disabled");
  // Divisor 3 gives two high and two low cycles, so three equal samples are a fault
  bclk_run_a: assert property (bclk_on [*4] |->
    !(o_request_to_send_n == $past(o_request_to_send_n) && o_request_to_send_n == $past(o_request_to_send_n, 2)))
    else $error("baud clock output stuck");
endmodule

bind uart_port uart_port_properties u_props (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr_be(i_wr_be), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_serial_in(i_serial_in),
  .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe), .i_clear_to_send_n(i_clear_to_send_n),
  .o_request_to_send_n(o_request_to_send_n), .o_request_to_send_oe(o_request_to_send_oe), .o_tx_irq(o_tx_irq),
  .o_rx_irq(o_rx_irq));

// File: dv/serial_peer.sv
// Behavioural remote serial device that sends and captures frames
module serial_peer (
  input  wire logic i_clk_sys,
  input  wire logic i_line,
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_line = 1'b1;

  // Bit 0 of the frame goes first; idle mark level between frames
  task automatic send(input logic [15:0] f, input int n, input int cyc);
    for (int i = 0; i < n; i++)
    begin
      o_line <= f[i];
      repeat (cyc) @(posedge i_clk_sys);
    end
    o_line <= 1'b1;
    repeat (2 * cyc) @(posedge i_clk_sys);
  endtask

  // Centre sampling; a missing start bit leaves all ones, which never matches
  task automatic recv(output logic [15:0] f, input int n, input int cyc, input int lim);
    int w;
    f = 16'hffff;
    w = 0;
    do
    begin
      @(posedge i_clk_sys);
      #1;
      w++;
    end
    while (i_line !== 1'b0 && w < lim);
    if (i_line === 1'b0)
      for (int i = 0; i < n; i++)
      begin
        repeat ((i == 0) ? cyc / 2 : cyc) @(posedge i_clk_sys);
        #1 f[i] = i_line;
      end
  endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the serial port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_pkg::*;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        wr_stb  = 1'b0;
  logic        rd_stb  = 1'b0;
  logic        cts_n   = 1'b0;
  logic [2:0]  addr    = 3'h0;
  logic [15:0] wdata   = 16'h0000;
  logic [1:0]  be      = 2'h0;
  logic [15:0] rdata, s, f;
  logic        sin, sout, sout_oe, rts_n, rts_oe, txi, rxi;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          tx_cnt    = 0;
  int          rx_cnt    = 0;

  uart_port u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr_be(be), .i_wr(wr_stb),
    .i_rd(rd_stb), .o_rdata(rdata), .i_serial_in(sin), .o_serial_out(sout), .o_serial_out_oe(sout_oe),
    .i_clear_to_send_n(cts_n), .o_request_to_send_n(rts_n), .o_request_to_send_oe(rts_oe), .o_tx_irq(txi),
    .o_rx_irq(rxi));
  serial_peer u_peer (.i_clk_sys(clk), .i_line(sout), .o_line(sin));

  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (txi === 1'b1) tx_cnt++;
    if (rxi === 1'b1) rx_cnt++;
  end

  task automatic reg_wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] b);
    addr   <= a;
    wdata  <= d;
    be     <= b;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  function automatic logic [15:0] mk(input logic [8:0] d, input int nd, input int pm);
    logic [15:0] r;
    r = 16'hffff;
    r[0] = 1'b0;
    for (int i = 0; i < nd; i++)
      r[i + 1] = d[i];
    if (pm != 0)
      r[nd + 1] = (pm == 1) ? ^d[7:0] : ~^d[7:0];
    return r;
  endfunction

  task automatic t_regs();
    reg_rd(ADDR_MODE, s); chk(s, RST_MODE);
    reg_rd(ADDR_BRG, s); chk(s, RST_DIV);
    reg_rd(3'h7, s); chk(s, 16'h0000);
    reg_wr(ADDR_MODE, 16'h4400, 2'h3);
    reg_rd(ADDR_MODE, s); chk(s, 16'h0000);
    reg_wr(ADDR_BRG, 16'hbeef, 2'h3);
    reg_rd(ADDR_BRG, s); chk(s, 16'hbeef);
  endtask

  task automatic t_tx();
    reg_wr(ADDR_MODE, 16'h8000, 2'h3);
    reg_wr(ADDR_STA, 16'h0400, 2'h3);
    repeat (4) @(posedge clk);
    chk(16'(tx_cnt), 16'h0001);
    // Encodings 8N, 8E, 8O with two stops, then 9N at high speed
    for (int k = 0; k < 4; k++)
    begin
      reg_wr(ADDR_BRG, (k == 3) ? 16'h0002 : 16'h0000, 2'h3);
      reg_wr(ADDR_MODE, 16'h8000 | 16'(k << 1) | (k == 3 ? 16'h0008 : 16'h0000) | (k == 2 ? 16'h0001 : 16'h0000), 2'h3);
      if (k == 3) reg_wr(ADDR_TXREG, 16'h0000, 2'h1);
      reg_wr(ADDR_TXREG, 16'h01c3, (k == 3) ? 2'h3 : 2'h1);
      u_peer.recv(f, (k == 0) ? 10 : (k == 2) ? 13 : 11, (k == 3) ? 12 : 16, 3);
      chk(f, mk(9'h1c3, (k == 3) ? 9 : 8, (k == 3) ? 0 : k));
      repeat (20) @(posedge clk);
    end
  endtask

  task automatic t_irq();
    logic [1:0] m [3] = '{2'b00, 2'b01, 2'b10};
    int         e [3] = '{3, 1, 2};
    int         base;
    reg_wr(ADDR_BRG, 16'h0000, 2'h3);
    reg_wr(ADDR_MODE, 16'h8000, 2'h3);
    for (int k = 0; k < 3; k++)
    begin
      reg_wr(ADDR_STA, {m[k][1], 1'b0, m[k][0], 13'h0400}, 2'h3);
      repeat (4) @(posedge clk);
      base = tx_cnt;
      repeat (3) reg_wr(ADDR_TXREG, 16'h0011, 2'h1);
      repeat (600) @(posedge clk);
      chk(16'(tx_cnt - base), 16'(e[k]));
    end
  endtask

  task automatic t_brk();
    reg_wr(ADDR_STA, 16'h0000, 2'h3);
    reg_wr(ADDR_TXREG, 16'h003c, 2'h1);
    reg_wr(ADDR_STA, 16'h0400, 2'h3);
    u_peer.recv(f, 10, 16, 4);
    chk(f, mk(9'h03c, 8, 0));
    repeat (20) @(posedge clk);
    reg_wr(ADDR_STA, 16'h0c00, 2'h3);
    reg_wr(ADDR_TXREG, 16'h00ff, 2'h1);
    reg_wr(ADDR_TXREG, 16'h0055, 2'h1);
    u_peer.recv(f, 14, 16, 4);
    chk(f, 16'he000);
    u_peer.recv(f, 10, 16, 40);
    chk(f, mk(9'h055, 8, 0));
    reg_rd(ADDR_STA, s); chk(s & 16'h0800, 16'h0000);
  endtask

  task automatic t_rx();
    logic [7:0]  d  [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h66};
    logic [15:0] fl [4] = '{16'h0004, 16'h0008, 16'h0000, 16'h0000};
    int          base;
    reg_wr(ADDR_MODE, 16'h8202, 2'h3);
    reg_wr(ADDR_STA, 16'h1000, 2'h3);
    base = rx_cnt;
    // Second frame has a bad stop, third a bad parity bit
    for (int i = 0; i < 5; i++)
    begin
      f = mk({1'b0, d[i]}, 8, 1);
      if (i == 1) f[10] = 1'b0;
      if (i == 2) f[9] = ~f[9];
      u_peer.send(f, 11, 16);
      if (i == 3) chk(16'(rx_cnt - base), 16'h0004);
      if (i == 3) chk({15'h0, rts_n}, 16'h0001);
    end
    reg_rd(ADDR_STA, s); chk(s & 16'h000f, 16'h0003);
    for (int i = 0; i < 4; i++)
    begin
      reg_rd(ADDR_RXREG, s); chk(s, {8'h00, d[i]});
      reg_rd(ADDR_STA, s); chk(s & ((i < 3) ? 16'h000e : 16'h0002), fl[i] | 16'h0002);
    end
    chk({15'h0, rts_n}, 16'h0000);
    reg_wr(ADDR_STA, 16'h1000, 2'h3);
    reg_rd(ADDR_STA, s); chk(s & 16'h0003, 16'h0000);
    // Flow control: clear-to-send held off blocks the queued character
    cts_n <= 1'b1;
    reg_wr(ADDR_STA, 16'h1400, 2'h3);
    reg_wr(ADDR_TXREG, 16'h005a, 2'h1);
    repeat (40) @(posedge clk);
    cts_n <= 1'b0;
    chk({15'h0, sout}, 16'h0001);
    u_peer.recv(f, 11, 16, 4);
    chk(f, mk(9'h05a, 8, 1));
  endtask

  task automatic t_loop();
    reg_wr(ADDR_MODE, 16'h8046, 2'h3);
    reg_wr(ADDR_STA, 16'h1420, 2'h3);
    reg_wr(ADDR_TXREG, 16'h0012, 2'h3);
    reg_wr(ADDR_TXREG, 16'h0134, 2'h3);
    repeat (400) @(posedge clk);
    reg_rd(ADDR_STA, s); chk(s & 16'h0001, 16'h0001);
    reg_rd(ADDR_RXREG, s); chk(s, 16'h0134);
    reg_rd(ADDR_STA, s); chk(s & 16'h0001, 16'h0000);
  endtask

  task automatic t_bclk();
    int n;
    reg_wr(ADDR_BRG, 16'h0003, 2'h3);
    reg_wr(ADDR_MODE, 16'h8300, 2'h3);
    repeat (4) @(posedge clk);
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1 n += int'(rts_n);
    end
    chk(16'(n), 16'h0014);
    chk({15'h0, rts_oe}, 16'h0001);
    reg_wr(ADDR_MODE, 16'h8000, 2'h3);
    repeat (2) @(posedge clk);
    chk({15'h0, rts_oe}, 16'h0000);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    $display("registers done");
    t_tx();
    $display("transmit done");
    t_irq();
    $display("transmit interrupts done");
    t_brk();
    $display("break done");
    t_rx();
    $display("receive done");
    t_loop();
    $display("loopback done");
    t_bclk();
    $display("baud clock done");
    summarize();
  end

  // Whole run needs about 5000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
